// [rtl/dbp_regs.svh]
// Register indices, field positions, reset values and the summary of operation.
// Summary of operation
// - Port A has five pins, each an input or an output under its own direction bit.
// - A direction bit at one turns the pin driver off so the pin is an input.
// - A direction bit at zero drives the pin with its output latch bit.
// - After power-on every port A pin is an input and the latch holds zero.
// - Reading a value register returns the pin levels; writing updates only the latch.
// - Every value write is read-modify-write: pins are read, written bytes replace them, latch stores.
// - Port A bit 4 feeds the timer clock input and its driver is open-drain, never high.
// - Port A direction and value bits 7 to 5 read as zero and ignore writes.
// - Any reset sets the port A direction bits to ones; only power-on touches the latch.
// - Any reset sets the port B direction bits to ones; only power-on touches the latch.
// - Every port B pin has a weak pull-up that software switches on or off.
// - Port B bit 0 is also the external interrupt input.
// - A level change on a port B input pin among bits 4 to 7 raises the port-change flag.
// - In programming mode port B bits 6 and 7 carry clock and data from the programmer.
// - A pin whose timer clock or programming function is enabled is taken away from general use; the interrupt inputs are not.
`ifndef DBP_REGS_SVH
`define DBP_REGS_SVH

`define DBP_IDX_A_VALUE     8'h05
`define DBP_IDX_B_VALUE     8'h06
`define DBP_IDX_INT_CTRL    8'h0b
`define DBP_IDX_INT_CTRL_HI 8'h8b
`define DBP_IDX_OPTION      8'h81
`define DBP_IDX_A_DIR       8'h85
`define DBP_IDX_B_DIR       8'h86
`define DBP_IDX_IRQ_STATUS  8'h90
`define DBP_IDX_IRQ_MASK    8'h91

`define DBP_ADDR(idx) {2'h0, idx, 2'h0}

`define DBP_A_DIR_RESET   5'h1f
`define DBP_B_DIR_RESET   8'hff
`define DBP_OPTION_RESET  8'hff
`define DBP_A_LATCH_RESET 5'h00
`define DBP_B_LATCH_RESET 8'h00

`define DBP_OPT_PULLUP_DIS_N 7
`define DBP_OPT_EDGE_SEL     6
`define DBP_OPT_TIMER_EXT    5

`define DBP_IRQ_PORT_CHANGE 0
`define DBP_IRQ_EXTERNAL    1

`define DBP_ICTL_EXT_EN  4
`define DBP_ICTL_CHG_EN  3
`define DBP_ICTL_EXT_FLG 1
`define DBP_ICTL_CHG_FLG 0

`define DBP_A_TIMER_BIT 4
`define DBP_B_EXT_BIT   0
`define DBP_B_CHG_LO    4
`define DBP_B_PCLK_BIT  6
`define DBP_B_PDAT_BIT  7

`endif

// [rtl/dbp_pkg.sv]
// Types shared by the dual pin port.
package dbp_pkg;
  typedef logic [7:0]  dbp_byte_t;
  typedef logic [4:0]  dbp_port_a_t;
  typedef logic [11:0] dbp_addr_t;
  typedef logic [31:0] dbp_word_t;
  typedef logic [1:0]  dbp_irq_t;
endpackage

// [rtl/dbp_pin_cell.sv]
// One general-purpose pin: driver control, open-drain option and weak pull-up.
`timescale 1ns/1ps
`default_nettype none
module dbp_pin_cell #(
  parameter bit OPEN_DRAIN = 1'b0,
  parameter bit HAS_PULLUP = 1'b0
) (
  input  wire logic dir,
  input  wire logic latch,
  input  wire logic force_input,
  input  wire logic pullup_disable_n,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pullup_en
);
  wire logic is_input;

  assign is_input  = dir | force_input;
  // An open-drain pin only ever pulls low, so it drives only for a zero latch.
  assign pad_out   = OPEN_DRAIN ? 1'b0 : latch;
  assign pad_oe    = OPEN_DRAIN ? (~is_input & ~latch) : ~is_input;
  assign pullup_en = HAS_PULLUP & ~pullup_disable_n & is_input;
endmodule // dbp_pin_cell
`default_nettype wire

// [rtl/dbp_sticky.sv]
// Sticky event flag whose set wins over a same-cycle clear.
`timescale 1ns/1ps
`default_nettype none
module dbp_sticky (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_q
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end
endmodule // dbp_sticky
`default_nettype wire

// [rtl/dbp_port.sv]
// Dual bidirectional pin port with APB registers and interrupt flags.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "dbp_regs.svh"
module dbp_port (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              sys_reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire dbp_pkg::dbp_addr_t paddr,
  input  wire dbp_pkg::dbp_word_t pwdata,
  input  wire logic [3:0]        pstrb,
  output dbp_pkg::dbp_word_t     prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire dbp_pkg::dbp_port_a_t pin_a_in,
  output dbp_pkg::dbp_port_a_t   pin_a_out,
  output dbp_pkg::dbp_port_a_t   pin_a_oe,
  input  wire dbp_pkg::dbp_byte_t pin_b_in,
  output dbp_pkg::dbp_byte_t     pin_b_out,
  output dbp_pkg::dbp_byte_t     pin_b_oe,
  output dbp_pkg::dbp_byte_t     pin_b_pullup_en,
  output logic                   timer_external_clock_input,
  input  wire logic              prog_mode,
  output logic                   group_b_bit6_prog_clock,
  output logic                   group_b_bit7_prog_data,
  output logic                   irq
);
  import dbp_pkg::*;

  dbp_port_a_t dir_a_q;
  dbp_port_a_t latch_a_q;
  dbp_byte_t   dir_b_q;
  dbp_byte_t   latch_b_q;
  dbp_byte_t   option_q;
  dbp_irq_t    mask_q;
  dbp_byte_t   snap_b_q;
  logic        ext_prev_q;
  dbp_word_t   prdata_q;
  dbp_irq_t    status;

  // Address decode.
  wire logic [7:0] idx;
  wire logic       in_range;
  wire logic       sel_a_val;
  wire logic       sel_b_val;
  wire logic       sel_ictl;
  wire logic       sel_opt;
  wire logic       sel_a_dir;
  wire logic       sel_b_dir;
  wire logic       sel_stat;
  wire logic       sel_mask;
  wire logic       mapped;
  wire logic       setup;
  wire logic       access;
  wire logic       wr;
  wire logic       rd;
  wire logic       wr_b0;

  assign idx       = paddr[9:2];
  assign in_range  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  assign sel_a_val = in_range && (idx == `DBP_IDX_A_VALUE);
  assign sel_b_val = in_range && (idx == `DBP_IDX_B_VALUE);
  assign sel_ictl  = in_range && ((idx == `DBP_IDX_INT_CTRL) || (idx == `DBP_IDX_INT_CTRL_HI));
  assign sel_opt   = in_range && (idx == `DBP_IDX_OPTION);
  assign sel_a_dir = in_range && (idx == `DBP_IDX_A_DIR);
  assign sel_b_dir = in_range && (idx == `DBP_IDX_B_DIR);
  assign sel_stat  = in_range && (idx == `DBP_IDX_IRQ_STATUS);
  assign sel_mask  = in_range && (idx == `DBP_IDX_IRQ_MASK);
  assign mapped    = sel_a_val | sel_b_val | sel_ictl | sel_opt | sel_a_dir | sel_b_dir
                     | sel_stat | sel_mask;
  assign setup     = psel & ~penable;
  assign access    = psel & penable;
  assign wr        = access & pwrite & mapped;
  assign rd        = access & ~pwrite & mapped;
  assign wr_b0     = wr & pstrb[0];

  assign pready  = access;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_q;

  // Peripheral takeover of shared pins.
  wire logic       timer_ext_sel;
  wire logic [4:0] force_a;
  wire logic [7:0] force_b;

  assign timer_ext_sel = option_q[`DBP_OPT_TIMER_EXT];
  assign force_a = {timer_ext_sel, 4'h0};
  assign force_b = {prog_mode, prog_mode, 6'h00};

  assign timer_external_clock_input = pin_a_in[`DBP_A_TIMER_BIT];
  assign group_b_bit6_prog_clock    = prog_mode & pin_b_in[`DBP_B_PCLK_BIT];
  assign group_b_bit7_prog_data     = prog_mode & pin_b_in[`DBP_B_PDAT_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_pin_a
      dbp_pin_cell #(
        .OPEN_DRAIN (gi == `DBP_A_TIMER_BIT),
        .HAS_PULLUP (1'b0)
      ) u_cell (
        .dir              (dir_a_q[gi]),
        .latch            (latch_a_q[gi]),
        .force_input      (force_a[gi]),
        .pullup_disable_n (1'b1),
        .pad_out          (pin_a_out[gi]),
        .pad_oe           (pin_a_oe[gi]),
        .pullup_en        ()
      );
    end
    for (gi = 0; gi < 8; gi++) begin : g_pin_b
      dbp_pin_cell #(
        .OPEN_DRAIN (1'b0),
        .HAS_PULLUP (1'b1)
      ) u_cell (
        .dir              (dir_b_q[gi]),
        .latch            (latch_b_q[gi]),
        .force_input      (force_b[gi]),
        .pullup_disable_n (option_q[`DBP_OPT_PULLUP_DIS_N]),
        .pad_out          (pin_b_out[gi]),
        .pad_oe           (pin_b_oe[gi]),
        .pullup_en        (pin_b_pullup_en[gi])
      );
    end
  endgenerate

  // Read-modify-write: a byte lane left unwritten still stores the pin levels,
  // so input pins overwrite their latch bits just as a bit operation would.
  wire dbp_port_a_t latch_a_d;
  wire dbp_byte_t   latch_b_d;

  assign latch_a_d = wr_b0 ? pwdata[4:0] : pin_a_in;
  assign latch_b_d = wr_b0 ? pwdata[7:0] : pin_b_in;

  // Directions: power-on and the other reset both force inputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_a_q <= `DBP_A_DIR_RESET;
      dir_b_q <= `DBP_B_DIR_RESET;
    end else if (sys_reset) begin
      dir_a_q <= `DBP_A_DIR_RESET;
      dir_b_q <= `DBP_B_DIR_RESET;
    end else begin
      if (wr_b0 && sel_a_dir) begin
        dir_a_q <= pwdata[4:0];
      end
      if (wr_b0 && sel_b_dir) begin
        dir_b_q <= pwdata[7:0];
      end
    end
  end

  // Latches survive the other reset untouched.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_a_q <= `DBP_A_LATCH_RESET;
      latch_b_q <= `DBP_B_LATCH_RESET;
    end else begin
      if (wr && sel_a_val) begin
        latch_a_q <= latch_a_d;
      end
      if (wr && sel_b_val) begin
        latch_b_q <= latch_b_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_q <= `DBP_OPTION_RESET;
      mask_q   <= 2'h0;
    end else if (sys_reset) begin
      option_q <= `DBP_OPTION_RESET;
    end else if (wr_b0) begin
      if (sel_opt) begin
        option_q <= pwdata[7:0];
      end else if (sel_mask) begin
        mask_q <= pwdata[1:0];
      end else if (sel_ictl) begin
        mask_q <= {pwdata[`DBP_ICTL_EXT_EN], pwdata[`DBP_ICTL_CHG_EN]};
      end
    end
  end

  // Port-change reference: any access to the port B value counts as a read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_b_q   <= 8'h00;
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= pin_b_in[`DBP_B_EXT_BIT];
      if ((rd || wr) && sel_b_val) begin
        snap_b_q <= pin_b_in;
      end
    end
  end

  // Events.
  wire logic [3:0] chg_diff;
  wire logic       chg_event;
  wire logic       ext_rise;
  wire logic       ext_fall;
  wire logic       ext_event;
  wire dbp_irq_t   stat_clr;

  assign chg_diff  = (pin_b_in[7:4] ^ snap_b_q[7:4]) & dir_b_q[7:4];
  assign chg_event = |chg_diff;
  assign ext_rise  = pin_b_in[`DBP_B_EXT_BIT] & ~ext_prev_q;
  assign ext_fall  = ~pin_b_in[`DBP_B_EXT_BIT] & ext_prev_q;
  assign ext_event = option_q[`DBP_OPT_EDGE_SEL] ? ext_rise : ext_fall;
  assign stat_clr  = (wr_b0 && sel_stat) ? pwdata[1:0] : 2'h0;

  dbp_sticky u_flag_chg (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (chg_event),
    .clr     (stat_clr[`DBP_IRQ_PORT_CHANGE]),
    .flag_q  (status[`DBP_IRQ_PORT_CHANGE])
  );

  dbp_sticky u_flag_ext (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (ext_event),
    .clr     (stat_clr[`DBP_IRQ_EXTERNAL]),
    .flag_q  (status[`DBP_IRQ_EXTERNAL])
  );

  assign irq = |(status & mask_q);

  // Read data is captured in the setup cycle so the access phase needs no wait.
  wire dbp_byte_t ictl_view;
  wire dbp_byte_t rd_byte;

  assign ictl_view = {3'h0, mask_q[`DBP_IRQ_EXTERNAL], mask_q[`DBP_IRQ_PORT_CHANGE], 1'b0,
                      status[`DBP_IRQ_EXTERNAL], status[`DBP_IRQ_PORT_CHANGE]};
  assign rd_byte = sel_a_val ? {3'h0, pin_a_in} :
                   sel_b_val ? pin_b_in :
                   sel_ictl  ? ictl_view :
                   sel_opt   ? option_q :
                   sel_a_dir ? {3'h0, dir_a_q} :
                   sel_b_dir ? dir_b_q :
                   sel_stat  ? {6'h00, status} :
                   sel_mask  ? {6'h00, mask_q} : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // Checks. Each property restates a rule in terms of pins and registers, and many also use the
  // decode expressions above (wr_b0, sel_a_dir and the like), so a slip in the decode need not show up here.
  dir_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    sys_reset |=> (dir_a_q == `DBP_A_DIR_RESET) && (dir_b_q == `DBP_B_DIR_RESET))
    else $error("directions not forced to inputs by reset");

  dir_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_b0 && sel_a_dir && !sys_reset) |=> (dir_a_q == $past(pwdata[4:0])))
    else $error("port A direction write lost");

  latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sys_reset && !psel) |=> $stable(latch_b_q) && $stable(latch_a_q))
    else $error("latch changed by the other reset");

  latch_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && (sel_a_val || sel_b_val)) |=> $stable(latch_a_q) && $stable(latch_b_q))
    else $error("latch changed without a value write");

  latch_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_b0 && sel_b_val) |=> (latch_b_q == $past(pwdata[7:0])))
    else $error("port B latch does not hold the written byte");

  drive_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!prog_mode) |-> (pin_b_oe == ~dir_b_q) && (pin_b_out == latch_b_q))
    else $error("port B driver does not follow direction and latch");

  pin_a_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_a_oe[3:0] == ~dir_a_q[3:0]) && (pin_a_out[3:0] == latch_a_q[3:0]))
    else $error("port A driver does not follow direction and latch");

  open_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pin_a_out[`DBP_A_TIMER_BIT] &&
      (!pin_a_oe[`DBP_A_TIMER_BIT] || !latch_a_q[`DBP_A_TIMER_BIT]))
    else $error("open-drain pin driven high");

  timer_takeover_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_ext_sel |-> !pin_a_oe[`DBP_A_TIMER_BIT])
    else $error("timer clock pin still driven");

  upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && (sel_a_dir || sel_a_val)) |=> (prdata[7:5] == 3'h0))
    else $error("unimplemented port A bits read nonzero");

  pin_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && sel_b_val) |=> (prdata[7:0] == $past(pin_b_in)))
    else $error("port B read does not return pin levels");

  rmw_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && sel_a_val && !pstrb[0]) |=> (latch_a_q == $past(pin_a_in)))
    else $error("unwritten lane did not store pin levels");

  snap_update_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((rd || wr) && sel_b_val) |=> (snap_b_q == $past(pin_b_in)))
    else $error("port change reference not refreshed by a port access");

  change_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    chg_event |=> status[`DBP_IRQ_PORT_CHANGE])
    else $error("port change flag not raised");

  status_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_b0 && sel_stat && pwdata[`DBP_IRQ_PORT_CHANGE] && !chg_event)
      |=> !status[`DBP_IRQ_PORT_CHANGE])
    else $error("port change flag not cleared by a one");

  ext_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_event |=> status[`DBP_IRQ_EXTERNAL] ##1
      (irq || !mask_q[`DBP_IRQ_EXTERNAL] || !status[`DBP_IRQ_EXTERNAL]))
    else $error("external interrupt flag not raised");

  ext_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    (option_q[`DBP_OPT_EDGE_SEL] && $rose(pin_b_in[`DBP_B_EXT_BIT]))
      |=> status[`DBP_IRQ_EXTERNAL])
    else $error("rising edge on the interrupt pin missed");

  ext_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!option_q[`DBP_OPT_EDGE_SEL] && $fell(pin_b_in[`DBP_B_EXT_BIT]))
      |=> status[`DBP_IRQ_EXTERNAL])
    else $error("falling edge on the interrupt pin missed");

  pullup_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    |pin_b_pullup_en |-> !option_q[`DBP_OPT_PULLUP_DIS_N])
    else $error("pull-up on while disabled");

  pullup_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!option_q[`DBP_OPT_PULLUP_DIS_N] && (&dir_b_q)) |-> (&pin_b_pullup_en))
    else $error("pull-up missing on an input pin");

  prog_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    prog_mode |-> (pin_b_oe[7:6] == 2'h0))
    else $error("programming pins driven in programming mode");
endmodule // dbp_port
`default_nettype wire

// [testbench/dbp_board.sv]
// Board model: external drivers, pull-downs on group A and the weak pull-ups on group B.
`timescale 1ns/1ps
`default_nettype none
module dbp_board (
  input  wire logic                 pclk,
  input  wire dbp_pkg::dbp_port_a_t pin_a_out,
  input  wire dbp_pkg::dbp_port_a_t pin_a_oe,
  input  wire dbp_pkg::dbp_port_a_t drv_a_en,
  input  wire dbp_pkg::dbp_port_a_t drv_a_val,
  input  wire dbp_pkg::dbp_byte_t   pin_b_out,
  input  wire dbp_pkg::dbp_byte_t   pin_b_oe,
  input  wire dbp_pkg::dbp_byte_t   pin_b_pullup_en,
  input  wire dbp_pkg::dbp_byte_t   drv_b_en,
  input  wire dbp_pkg::dbp_byte_t   drv_b_val,
  output dbp_pkg::dbp_port_a_t      pin_a_in,
  output dbp_pkg::dbp_byte_t        pin_b_in
);
  import dbp_pkg::*;
  // A released group B line without pull-up toggles, so a settled unknown never passes.
  dbp_byte_t float_q = 8'h55;
  always @(posedge pclk) begin
    float_q <= ~float_q;
  end
  // The device driver wins over the board, which sits behind series resistors.
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_a_in[i] = pin_a_oe[i] ? pin_a_out[i] : (drv_a_en[i] ? drv_a_val[i] : 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      pin_b_in[i] = pin_b_oe[i] ? pin_b_out[i] : drv_b_en[i] ? drv_b_val[i] :
                    pin_b_pullup_en[i] ? 1'b1 : float_q[i];
    end
  end
endmodule // dbp_board
`default_nettype wire

// [testbench/dual_bidir_pin_port_test.sv]
// Self-checking bench for the dual pin port, driving pins through the board model.
`timescale 1ns/1ps
`default_nettype none
`include "dbp_regs.svh"
module dual_bidir_pin_port_test;
  import dbp_pkg::*;
  localparam dbp_addr_t A_VAL = `DBP_ADDR(`DBP_IDX_A_VALUE);
  localparam dbp_addr_t B_VAL = `DBP_ADDR(`DBP_IDX_B_VALUE);
  localparam dbp_addr_t ICTL  = `DBP_ADDR(`DBP_IDX_INT_CTRL);
  localparam dbp_addr_t ICTL_HI = `DBP_ADDR(`DBP_IDX_INT_CTRL_HI);
  localparam dbp_addr_t OPT   = `DBP_ADDR(`DBP_IDX_OPTION);
  localparam dbp_addr_t A_DIR = `DBP_ADDR(`DBP_IDX_A_DIR);
  localparam dbp_addr_t B_DIR = `DBP_ADDR(`DBP_IDX_B_DIR);
  localparam dbp_addr_t STAT  = `DBP_ADDR(`DBP_IDX_IRQ_STATUS);
  localparam dbp_addr_t MASK  = `DBP_ADDR(`DBP_IDX_IRQ_MASK);
  logic        pclk, presetn, sys_reset, psel, penable, pwrite, prog_mode;
  logic        pready, pslverr, irq, tmr_clk, prg_clk, prg_dat, err;
  logic [3:0]  pstrb;
  dbp_addr_t   paddr;
  dbp_word_t   pwdata, prdata, rd;
  dbp_port_a_t pin_a_in, pin_a_out, pin_a_oe, drv_a_en, drv_a_val, lat;
  dbp_byte_t   pin_b_in, pin_b_out, pin_b_oe, pin_b_pu, drv_b_en, drv_b_val, latb;
  int          fail_count, n_checks;
  integer      seed;

  dbp_port dut (.pclk(pclk), .presetn(presetn), .sys_reset(sys_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_a_in(pin_a_in),
    .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_in(pin_b_in), .pin_b_out(pin_b_out),
    .pin_b_oe(pin_b_oe), .pin_b_pullup_en(pin_b_pu), .timer_external_clock_input(tmr_clk),
    .prog_mode(prog_mode), .group_b_bit6_prog_clock(prg_clk),
    .group_b_bit7_prog_data(prg_dat), .irq(irq));
  dbp_board board (.pclk(pclk), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
    .drv_a_en(drv_a_en), .drv_a_val(drv_a_val), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe),
    .pin_b_pullup_en(pin_b_pu), .drv_b_en(drv_b_en), .drv_b_val(drv_b_val),
    .pin_a_in(pin_a_in), .pin_b_in(pin_b_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task automatic apb(input logic w, input dbp_addr_t a, input dbp_word_t d, input logic [3:0] s);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input dbp_addr_t a, input dbp_byte_t d);
    apb(1'b1, a, {24'h0, d}, 4'hf);
  endtask

  task automatic rdchk(input dbp_addr_t a, input dbp_word_t exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
  endtask

  initial begin
    seed = 32'hb21cbd23;
    fail_count = 0;
    n_checks = 0;
    presetn = 1'b0;
    sys_reset = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    prog_mode = 1'b0;
    drv_a_en = '0;
    drv_a_val = '0;
    drv_b_en = 8'hff;
    drv_b_val = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({pin_a_oe, pin_b_oe, pin_b_pu}, 32'h0);
    rdchk(A_DIR, 32'h1f);
    rdchk(B_DIR, 32'hff);
    rdchk(A_VAL, 32'h0);
    rdchk(12'h3f0, 32'h0);
    chk(err, 1'b1);
    wr(A_DIR, 8'he0);
    rdchk(A_DIR, 32'h0);
    // The timer clock is taken off pin 4 first, since while selected it forces that pin
    // to an input; then random latches with every group A pin an output.
    wr(OPT, 8'hdf);
    for (int i = 0; i < 6; i++) begin
      lat = dbp_port_a_t'($random(seed));
      wr(A_VAL, {3'h0, lat});
      @(negedge pclk);
      chk({pin_a_oe, pin_a_out}, {~lat[4], 4'hf, 1'b0, lat[3:0]});
      rdchk(A_VAL, {27'h0, 1'b0, lat[3:0]});
    end
    // A write with no byte strobe stores the pin levels the board drives.
    wr(A_DIR, 8'h1f);
    lat = dbp_port_a_t'($random(seed));
    drv_a_en <= 5'h1f;
    drv_a_val <= lat;
    apb(1'b1, A_VAL, 32'h0, 4'h0);
    chk(tmr_clk, lat[4]);
    drv_a_en <= 5'h00;
    wr(A_DIR, 8'h00);
    @(negedge pclk);
    chk({pin_a_oe, pin_a_out}, {~lat[4], 4'hf, 1'b0, lat[3:0]});
    latb = dbp_byte_t'($random(seed));
    wr(B_VAL, latb);
    wr(B_DIR, 8'h0f);
    wr(OPT, 8'h7f);
    @(negedge pclk);
    chk({pin_a_oe, pin_b_oe, pin_b_pu}, 21'h0ff00f);
    chk(pin_b_out, latb);
    @(posedge pclk);
    prog_mode <= 1'b1;
    drv_b_val <= 8'h80;
    @(negedge pclk);
    chk({pin_b_oe, prg_dat, prg_clk}, 10'h0c2);
    @(posedge pclk);
    prog_mode <= 1'b0;
    drv_b_val <= 8'h00;
    sys_reset <= 1'b1;
    @(posedge pclk);
    sys_reset <= 1'b0;
    @(negedge pclk);
    chk({pin_a_oe, pin_b_oe, pin_b_pu}, 32'h0);
    rdchk(B_DIR, 32'hff);
    chk(pin_b_out, latb);
    wr(A_DIR, 8'h00);
    @(negedge pclk);
    chk(pin_a_out, {1'b0, lat[3:0]});
    // Interrupt events: external edge in both senses and the port-change compare.
    rdchk(B_VAL, 32'h0);
    wr(STAT, 8'h03);
    wr(MASK, 8'h02);
    drv_b_val <= 8'h01;
    repeat (3) @(posedge pclk);
    rdchk(STAT, 32'h2);
    chk(irq, 1'b1);
    rdchk(ICTL, 32'h12);
    wr(STAT, 8'h02);
    rdchk(STAT, 32'h0);
    chk(irq, 1'b0);
    drv_b_val <= 8'h41;
    repeat (3) @(posedge pclk);
    rdchk(STAT, 32'h1);
    chk(irq, 1'b0);
    rdchk(B_VAL, 32'h41);
    wr(STAT, 8'h01);
    rdchk(STAT, 32'h0);
    wr(OPT, 8'hbf);
    drv_b_val <= 8'h40;
    repeat (3) @(posedge pclk);
    rdchk(STAT, 32'h2);
    wr(ICTL_HI, 8'h08);
    rdchk(MASK, 32'h1);
    chk(irq, 1'b0);
    drv_b_val <= 8'h00;
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1);
    tally_and_finish();
  end
endmodule // dual_bidir_pin_port_test
`default_nettype wire
